// ---- hw/timed_io_pkg.sv ----
package timed_io_pkg;

  // ----------------------------------------------------------------------
  // Sizes and timing
  // ----------------------------------------------------------------------
  localparam int XFER_W = 32;
  localparam int COUNT_W = 16;
  localparam int NUM_CLKBLK = 6;
  localparam int CLKSEL_W = 3;
  localparam int DIV_W = 8;
  localparam int SLOT_W = 6;
  localparam int CORE_CLK_MHZ = 100;
  localparam int REF_CLK_MHZ = 100;
  localparam int REF_TICK_CYCLES = CORE_CLK_MHZ / REF_CLK_MHZ;

  // ----------------------------------------------------------------------
  // Reset values and command field positions
  // ----------------------------------------------------------------------
  localparam logic [CLKSEL_W-1:0] CLKSEL_RST = 3'h0;
  localparam logic [COUNT_W-1:0] COUNT_RST = 16'h0000;
  localparam logic [DIV_W-1:0] DIV_RST = 8'h00;
  localparam int CFG_DIR_OUT_BIT = 0;
  localparam int CFG_OD_BIT = 1;
  localparam int CFG_STB_IN_BIT = 2;
  localparam int CFG_STB_OUT_BIT = 3;
  localparam int CFG_EN_BIT = 4;
  localparam int CFG_CLKSEL_LSB = 8;
  localparam int CBC_SRC_PIN_BIT = 0;
  localparam int CBC_DIV_LSB = 8;

  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_CONFIG = 4'h1,
    OP_OUT = 4'h2,
    OP_IN = 4'h3,
    OP_SET_TIME = 4'h4,
    OP_SET_COND = 4'h5,
    OP_GET_COUNT = 4'h6,
    OP_GET_STAMP = 4'h7,
    OP_CLK_CONFIG = 4'h8
  } op_t;

  typedef enum logic [1:0] {
    COND_NONE = 2'h0,
    COND_EQ = 2'h1,
    COND_NEQ = 2'h2
  } cond_t;

  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_OUT = 3'b010,
    ST_IN = 3'b100
  } port_state_t;

endpackage

// ---- hw/clock_blocks.sv ----
`timescale 1ns/1ns
module clock_blocks (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic cfg_we_in,
  input wire logic [timed_io_pkg::CLKSEL_W-1:0] cfg_idx_in,
  input wire logic cfg_src_pin_in,
  input wire logic [timed_io_pkg::DIV_W-1:0] cfg_div_in,
  input wire logic ext_clk_pin_in,
  output logic [timed_io_pkg::NUM_CLKBLK-1:0] tick_out
);

  localparam int N = timed_io_pkg::NUM_CLKBLK;
  localparam int RW = $clog2(timed_io_pkg::REF_TICK_CYCLES + 1);

  logic [RW-1:0] ref_cnt_q, ref_cnt_d;
  logic ext_prev_q;
  logic [N-1:0] src_pin_q, src_pin_d;
  logic [timed_io_pkg::DIV_W-1:0] div_q [N];
  logic [timed_io_pkg::DIV_W-1:0] div_d [N];
  logic [timed_io_pkg::DIV_W-1:0] cnt_q [N];
  logic [timed_io_pkg::DIV_W-1:0] cnt_d [N];
  logic ref_tick;
  logic ext_rise;

  // ----------------------------------------------------------------------
  // Next values
  // ----------------------------------------------------------------------
  // Block 0 is fixed to the reference tick; the others pick a source and divide it.
  always_comb begin
    ref_tick = (ref_cnt_q == RW'(timed_io_pkg::REF_TICK_CYCLES - 1));
    ref_cnt_d = ref_tick ? '0 : ref_cnt_q + RW'(1);
    ext_rise = ext_clk_pin_in & ~ext_prev_q;
    src_pin_d = src_pin_q;
    tick_out = '0;
    tick_out[0] = ref_tick;
    for (int i = 0; i < N; i++) begin
      div_d[i] = div_q[i];
      cnt_d[i] = cnt_q[i];
      if (i != 0) begin
        if (src_pin_q[i] ? ext_rise : ref_tick) begin
          if (cnt_q[i] == div_q[i]) begin
            cnt_d[i] = '0;
            tick_out[i] = 1'b1;
          end else begin
            cnt_d[i] = cnt_q[i] + 1'b1;
          end
        end
        if (cfg_we_in && cfg_idx_in == timed_io_pkg::CLKSEL_W'(i)) begin
          src_pin_d[i] = cfg_src_pin_in;
          div_d[i] = cfg_div_in;
          cnt_d[i] = '0;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // The pin is already synchronous, so one stage suffices for edge detection.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      ref_cnt_q <= '0;
      ext_prev_q <= 1'b0;
      src_pin_q <= '0;
      for (int i = 0; i < N; i++) begin
        div_q[i] <= timed_io_pkg::DIV_RST;
        cnt_q[i] <= '0;
      end
    end else begin
      ref_cnt_q <= ref_cnt_d;
      ext_prev_q <= ext_clk_pin_in;
      src_pin_q <= src_pin_d;
      for (int i = 0; i < N; i++) begin
        div_q[i] <= div_d[i];
        cnt_q[i] <= cnt_d[i];
      end
    end
  end

endmodule

// ---- hw/pin_share.sv ----
`timescale 1ns/1ns
module pin_share #(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] port_out_in,
  input wire logic [WIDTH-1:0] port_oe_in,
  input wire logic link_enable_in,
  input wire logic [WIDTH-1:0] link_out_in,
  input wire logic [WIDTH-1:0] link_oe_in,
  input wire logic [WIDTH-1:0] narrow_claim_in,
  input wire logic [WIDTH-1:0] narrow_out_in,
  input wire logic [WIDTH-1:0] narrow_oe_in,
  output logic [WIDTH-1:0] pin_out,
  output logic [WIDTH-1:0] pin_oe
);

  // ----------------------------------------------------------------------
  // Per-pin owner selection
  // ----------------------------------------------------------------------
  // Link beats narrow port beats this port; decided pin by pin.
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      if (link_enable_in) begin
        pin_out[i] = link_out_in[i];
        pin_oe[i] = link_oe_in[i];
      end else if (narrow_claim_in[i]) begin
        pin_out[i] = narrow_out_in[i];
        pin_oe[i] = narrow_oe_in[i];
      end else begin
        pin_out[i] = port_out_in[i];
        pin_oe[i] = port_oe_in[i];
      end
    end
  end

endmodule

// ---- hw/timed_io_port.sv ----
`timescale 1ns/1ns
module timed_io_port #(
  parameter int WIDTH = 8
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic cmd_valid_in,
  input wire timed_io_pkg::op_t cmd_op_in,
  input wire logic [31:0] cmd_data_in,
  input wire logic [7:0] cmd_arg_in,
  output logic cmd_ready_out,
  output logic rsp_valid_out,
  output logic [31:0] rsp_data_out,
  output logic event_out,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out,
  output logic [WIDTH-1:0] pin_oe_out,
  input wire logic strobe_in,
  output logic strobe_out,
  input wire logic ext_clk_pin_in,
  input wire logic link_enable_in,
  input wire logic [WIDTH-1:0] link_pin_out_in,
  input wire logic [WIDTH-1:0] link_pin_oe_in,
  input wire logic [WIDTH-1:0] narrow_claim_in,
  input wire logic [WIDTH-1:0] narrow_pin_out_in,
  input wire logic [WIDTH-1:0] narrow_pin_oe_in
);

  localparam int XW = timed_io_pkg::XFER_W;
  localparam int CW = timed_io_pkg::COUNT_W;
  localparam int SW = timed_io_pkg::SLOT_W;
  localparam int SLOTS = XW / WIDTH;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  timed_io_pkg::port_state_t state_q, state_d;
  timed_io_pkg::cond_t cond_q, cond_d;
  logic od_q, od_d;
  logic stb_in_en_q, stb_in_en_d;
  logic stb_out_en_q, stb_out_en_d;
  logic [timed_io_pkg::CLKSEL_W-1:0] clksel_q, clksel_d;
  logic [CW-1:0] count_q, count_d;
  logic [CW-1:0] stamp_q, stamp_d;
  logic [CW-1:0] time_q, time_d;
  logic timed_q, timed_d;
  logic [WIDTH-1:0] cond_val_q, cond_val_d;
  logic [XW-1:0] xfer_q, xfer_d;
  logic xfer_full_q, xfer_full_d;
  logic [XW-1:0] shift_q, shift_d;
  logic [SW-1:0] slot_q, slot_d;
  logic [WIDTH-1:0] drive_q, drive_d;
  logic strobe_q, strobe_d;
  logic rsp_valid_q, rsp_valid_d;
  logic [31:0] rsp_q, rsp_d;
  logic event_q, event_d;

  logic [timed_io_pkg::NUM_CLKBLK-1:0] cb_tick;
  logic tick;
  logic time_ok;
  logic take;
  logic [XW-1:0] shift_in;
  logic [WIDTH-1:0] port_out;
  logic [WIDTH-1:0] port_oe;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Equality or inequality against the programmed value; none never holds.
  function automatic logic cond_met(input timed_io_pkg::cond_t mode,
                                    input logic [WIDTH-1:0] pins,
                                    input logic [WIDTH-1:0] value);
    logic hit;
    hit = 1'b0;
    unique case (mode)
      timed_io_pkg::COND_EQ: hit = (pins == value);
      timed_io_pkg::COND_NEQ: hit = (pins != value);
      timed_io_pkg::COND_NONE: hit = 1'b0;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  // ----------------------------------------------------------------------
  // Clock blocks and pin sharing
  // ----------------------------------------------------------------------
  // Clock block configuration rides on the same command stream as the port.
  clock_blocks u_clock_blocks (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .cfg_we_in(cmd_valid_in && cmd_op_in == timed_io_pkg::OP_CLK_CONFIG),
    .cfg_idx_in(cmd_arg_in[timed_io_pkg::CLKSEL_W-1:0]),
    .cfg_src_pin_in(cmd_data_in[timed_io_pkg::CBC_SRC_PIN_BIT]),
    .cfg_div_in(cmd_data_in[timed_io_pkg::CBC_DIV_LSB +: timed_io_pkg::DIV_W]),
    .ext_clk_pin_in(ext_clk_pin_in),
    .tick_out(cb_tick)
  );

  pin_share #(
    .WIDTH(WIDTH)
  ) u_pin_share (
    .port_out_in(port_out),
    .port_oe_in(port_oe),
    .link_enable_in(link_enable_in),
    .link_out_in(link_pin_out_in),
    .link_oe_in(link_pin_oe_in),
    .narrow_claim_in(narrow_claim_in),
    .narrow_out_in(narrow_pin_out_in),
    .narrow_oe_in(narrow_pin_oe_in),
    .pin_out(pin_out),
    .pin_oe(pin_oe_out)
  );

  // Only the selected clock block paces this port; selector codes 6 and 7
  // name no block and never tick, so a bad code stalls rather than aliases.
  assign tick = (clksel_q < timed_io_pkg::CLKSEL_W'(timed_io_pkg::NUM_CLKBLK)) ?
                cb_tick[clksel_q] : 1'b0;
  assign time_ok = !timed_q || (count_q == time_q);
  assign take = !stb_in_en_q || strobe_in;
  assign shift_in = (shift_q >> WIDTH) | (XW'(pin_in) << (XW - WIDTH));

  // Open-drain releases the pin for a one so an external pull-up sets the level.
  always_comb begin
    port_out = '0;
    port_oe = '0;
    if (state_q == timed_io_pkg::ST_OUT) begin
      if (od_q) begin
        port_out = '0;
        port_oe = ~drive_q;
      end else begin
        port_out = drive_q;
        port_oe = '1;
      end
    end
  end

  // A command that would have to wait is held off by ready rather than
  // stretched, so every accepted command finishes in the cycle it is taken.
  always_comb begin
    unique case (cmd_op_in)
      timed_io_pkg::OP_OUT: cmd_ready_out = !xfer_full_q;
      timed_io_pkg::OP_IN: cmd_ready_out = xfer_full_q;
      default: cmd_ready_out = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------------
  // Next values
  // ----------------------------------------------------------------------
  // Pin-side transfers are computed first; core commands follow and a pin-side
  // set of the full flag wins over the IN clear in the same cycle, while CONFIG clears it regardless.
  always_comb begin
    state_d = state_q;
    cond_d = cond_q;
    od_d = od_q;
    stb_in_en_d = stb_in_en_q;
    stb_out_en_d = stb_out_en_q;
    clksel_d = clksel_q;
    count_d = count_q;
    stamp_d = stamp_q;
    time_d = time_q;
    timed_d = timed_q;
    cond_val_d = cond_val_q;
    xfer_d = xfer_q;
    xfer_full_d = xfer_full_q;
    shift_d = shift_q;
    slot_d = slot_q;
    drive_d = drive_q;
    strobe_d = strobe_q;
    rsp_valid_d = 1'b0;
    rsp_d = rsp_q;
    event_d = 1'b0;
    if (tick) begin
      count_d = count_q + 1'b1;
      strobe_d = 1'b0;
    end
    // Output path: transfer register feeds the serializer, low slice first.
    if (tick && state_q == timed_io_pkg::ST_OUT) begin
      if (slot_q != '0) begin
        drive_d = shift_q[WIDTH-1:0];
        shift_d = shift_q >> WIDTH;
        slot_d = slot_q - 1'b1;
        strobe_d = stb_out_en_q;
      end else if (xfer_full_q && time_ok) begin
        drive_d = xfer_q[WIDTH-1:0];
        shift_d = xfer_q >> WIDTH;
        slot_d = SW'(SLOTS - 1);
        xfer_full_d = 1'b0;
        stamp_d = count_q;
        timed_d = 1'b0;
        strobe_d = stb_out_en_q;
        event_d = 1'b1;
      end
    end
    // Input path: a condition captures one sample, otherwise words assemble.
    if (tick && state_q == timed_io_pkg::ST_IN && time_ok) begin
      if (cond_q != timed_io_pkg::COND_NONE) begin
        if (take && cond_met(cond_q, pin_in, cond_val_q)) begin
          xfer_d = XW'(pin_in);
          xfer_full_d = 1'b1;
          stamp_d = count_q;
          cond_d = timed_io_pkg::COND_NONE;
          timed_d = 1'b0;
          event_d = 1'b1;
        end
      end else if (take) begin
        timed_d = 1'b0;
        shift_d = shift_in;
        if (slot_q == SW'(SLOTS - 1)) begin
          xfer_d = shift_in;
          xfer_full_d = 1'b1;
          stamp_d = count_q;
          slot_d = '0;
          event_d = 1'b1;
        end else begin
          slot_d = slot_q + 1'b1;
        end
      end
    end
    // Core commands.
    if (cmd_valid_in && cmd_ready_out) begin
      unique case (cmd_op_in)
        timed_io_pkg::OP_CONFIG: begin
          if (!cmd_data_in[timed_io_pkg::CFG_EN_BIT]) begin
            state_d = timed_io_pkg::ST_OFF;
          end else if (cmd_data_in[timed_io_pkg::CFG_DIR_OUT_BIT]) begin
            state_d = timed_io_pkg::ST_OUT;
          end else begin
            state_d = timed_io_pkg::ST_IN;
          end
          od_d = cmd_data_in[timed_io_pkg::CFG_OD_BIT];
          stb_in_en_d = cmd_data_in[timed_io_pkg::CFG_STB_IN_BIT];
          stb_out_en_d = cmd_data_in[timed_io_pkg::CFG_STB_OUT_BIT];
          clksel_d = cmd_data_in[timed_io_pkg::CFG_CLKSEL_LSB +: timed_io_pkg::CLKSEL_W];
          xfer_full_d = 1'b0;
          slot_d = '0;
          timed_d = 1'b0;
          cond_d = timed_io_pkg::COND_NONE;
          drive_d = '0;
        end
        timed_io_pkg::OP_OUT: begin
          xfer_d = cmd_data_in;
          xfer_full_d = 1'b1;
        end
        timed_io_pkg::OP_IN: begin
          rsp_d = xfer_q;
          rsp_valid_d = 1'b1;
          xfer_full_d = xfer_full_d && event_d;
        end
        timed_io_pkg::OP_SET_TIME: begin
          time_d = cmd_data_in[CW-1:0];
          timed_d = 1'b1;
        end
        timed_io_pkg::OP_SET_COND: begin
          cond_val_d = cmd_data_in[WIDTH-1:0];
          cond_d = timed_io_pkg::cond_t'(cmd_arg_in[1:0]);
        end
        timed_io_pkg::OP_GET_COUNT: begin
          rsp_d = 32'(count_q);
          rsp_valid_d = 1'b1;
        end
        timed_io_pkg::OP_GET_STAMP: begin
          rsp_d = 32'(stamp_q);
          rsp_valid_d = 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // Reset leaves the port off, on clock block 0, with the counter at zero.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state_q <= timed_io_pkg::ST_OFF;
      cond_q <= timed_io_pkg::COND_NONE;
      od_q <= 1'b0;
      stb_in_en_q <= 1'b0;
      stb_out_en_q <= 1'b0;
      clksel_q <= timed_io_pkg::CLKSEL_RST;
      count_q <= timed_io_pkg::COUNT_RST;
      stamp_q <= timed_io_pkg::COUNT_RST;
      time_q <= timed_io_pkg::COUNT_RST;
      timed_q <= 1'b0;
      cond_val_q <= '0;
      xfer_q <= '0;
      xfer_full_q <= 1'b0;
      shift_q <= '0;
      slot_q <= '0;
      drive_q <= '0;
      strobe_q <= 1'b0;
      rsp_valid_q <= 1'b0;
      rsp_q <= '0;
      event_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cond_q <= cond_d;
      od_q <= od_d;
      stb_in_en_q <= stb_in_en_d;
      stb_out_en_q <= stb_out_en_d;
      clksel_q <= clksel_d;
      count_q <= count_d;
      stamp_q <= stamp_d;
      time_q <= time_d;
      timed_q <= timed_d;
      cond_val_q <= cond_val_d;
      xfer_q <= xfer_d;
      xfer_full_q <= xfer_full_d;
      shift_q <= shift_d;
      slot_q <= slot_d;
      drive_q <= drive_d;
      strobe_q <= strobe_d;
      rsp_valid_q <= rsp_valid_d;
      rsp_q <= rsp_d;
      event_q <= event_d;
    end
  end
  // Response, event and strobe outputs come straight from flip-flops, so the core sees no glitches on them.
  assign rsp_valid_out = rsp_valid_q;
  assign rsp_data_out = rsp_q;
  assign event_out = event_q;
  assign strobe_out = strobe_q;

endmodule

// ---- tb/timed_io_port_assertions.sv ----
`timescale 1ns/1ns
module timed_io_port_assertions #(
  parameter int WIDTH = 8
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic cmd_valid_in,
  input wire timed_io_pkg::op_t cmd_op_in,
  input wire logic [31:0] cmd_data_in,
  input wire logic cmd_ready_out,
  input wire logic rsp_valid_out,
  input wire logic [31:0] rsp_data_out,
  input wire logic event_out,
  input wire logic [WIDTH-1:0] pin_out,
  input wire logic [WIDTH-1:0] pin_oe_out,
  input wire logic strobe_out,
  input wire logic link_enable_in,
  input wire logic [WIDTH-1:0] link_pin_out_in,
  input wire logic [WIDTH-1:0] link_pin_oe_in,
  input wire logic [WIDTH-1:0] narrow_claim_in,
  input wire logic [WIDTH-1:0] narrow_pin_out_in,
  input wire logic [WIDTH-1:0] narrow_pin_oe_in
);
  // --------------------------------------------------------------------
  // Configuration shadow
  // --------------------------------------------------------------------
  logic [7:0] cfg_q;
  logic [7:0] cfg_d;
  logic taken;
  logic rd_taken;
  logic c_out;
  logic c_od;
  logic c_en;

  // The pin checks need the port mode, which only shows as a past command.
  always_comb begin
    cfg_d = cfg_q;
    if (taken && cmd_op_in == timed_io_pkg::OP_CONFIG) begin
      cfg_d = cmd_data_in[7:0];
    end
  end
  // The shadow clears with the port on reset, so both start disabled.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      cfg_q <= 8'h00;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // Decoded command and mode bits.
  assign taken = cmd_valid_in && cmd_ready_out;
  assign rd_taken = taken && (cmd_op_in inside {timed_io_pkg::OP_IN, timed_io_pkg::OP_GET_COUNT,
                                                timed_io_pkg::OP_GET_STAMP});
  assign c_out = cfg_q[timed_io_pkg::CFG_DIR_OUT_BIT];
  assign c_od = cfg_q[timed_io_pkg::CFG_OD_BIT];
  assign c_en = cfg_q[timed_io_pkg::CFG_EN_BIT];

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);

  property p_read_answer;
    rd_taken |=> rsp_valid_out;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read gave no answer");

  property p_rsp_cause;
    rsp_valid_out |-> $past(rd_taken);
  endproperty
  a_rsp_cause: assert property (p_rsp_cause) else $error("answer without a read");

  property p_rsp_hold;
    !rsp_valid_out && !$past(rst_in) |-> $stable(rsp_data_out);
  endproperty
  a_rsp_hold: assert property (p_rsp_hold) else $error("read data moved");

  property p_ready_misc;
    cmd_valid_in && !(cmd_op_in inside {timed_io_pkg::OP_OUT, timed_io_pkg::OP_IN}) |->
      cmd_ready_out;
  endproperty
  a_ready_misc: assert property (p_ready_misc) else $error("command stalled");

  property p_link_owns;
    link_enable_in |-> pin_out == link_pin_out_in && pin_oe_out == link_pin_oe_in;
  endproperty
  a_link_owns: assert property (p_link_owns) else $error("link lost its pins");

  property p_narrow_owns;
    !link_enable_in |->
      (((pin_oe_out ^ narrow_pin_oe_in) | (pin_out ^ narrow_pin_out_in)) & narrow_claim_in) == '0;
  endproperty
  a_narrow_owns: assert property (p_narrow_owns) else $error("narrow pin taken");

  property p_in_no_drive;
    !link_enable_in && !c_out && !$past(c_out) |-> (pin_oe_out & ~narrow_claim_in) == '0;
  endproperty
  a_in_no_drive: assert property (p_in_no_drive) else $error("input port drives");

  property p_od_low;
    !link_enable_in && c_od && $past(c_od) |-> (pin_oe_out & pin_out & ~narrow_claim_in) == '0;
  endproperty
  a_od_low: assert property (p_od_low) else $error("open drain drove high");

  property p_wide_kept;
    event_out && !link_enable_in && c_en && c_out && !c_od |-> &(pin_oe_out | narrow_claim_in);
  endproperty
  a_wide_kept: assert property (p_wide_kept) else $error("unclaimed pin idle");

  property p_strobe_cfg;
    strobe_out |-> cfg_q[timed_io_pkg::CFG_STB_OUT_BIT] || $past(cfg_q[3]);
  endproperty
  a_strobe_cfg: assert property (p_strobe_cfg) else $error("strobe while disabled");
endmodule

bind timed_io_port timed_io_port_assertions #(.WIDTH(WIDTH)) u_timed_io_port_assertions (
  .clock_in(clock_in), .rst_in(rst_in), .cmd_valid_in(cmd_valid_in), .cmd_op_in(cmd_op_in),
  .cmd_data_in(cmd_data_in), .cmd_ready_out(cmd_ready_out), .rsp_valid_out(rsp_valid_out),
  .rsp_data_out(rsp_data_out), .event_out(event_out), .pin_out(pin_out),
  .pin_oe_out(pin_oe_out), .strobe_out(strobe_out), .link_enable_in(link_enable_in),
  .link_pin_out_in(link_pin_out_in), .link_pin_oe_in(link_pin_oe_in),
  .narrow_claim_in(narrow_claim_in), .narrow_pin_out_in(narrow_pin_out_in),
  .narrow_pin_oe_in(narrow_pin_oe_in)
);

// ---- tb/pin_partner.sv ----
`timescale 1ns/1ns
module pin_partner #(
  parameter int WIDTH = 8
) (
  input wire logic clock_in,
  input wire logic [WIDTH-1:0] pin_out_in,
  input wire logic [WIDTH-1:0] pin_oe_in,
  output logic [WIDTH-1:0] level_out,
  output logic strobe_level_out,
  output logic ext_clk_out
);
  logic [WIDTH-1:0] drv_q;
  logic drv_en_q;

  initial begin
    drv_q = '0;
    drv_en_q = 1'b0;
    strobe_level_out = 1'b0;
    ext_clk_out = 1'b0;
  end

  // The device wins where it drives; a released pin falls to its pull-down.
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      level_out[i] = pin_oe_in[i] ? pin_out_in[i] : (drv_en_q ? drv_q[i] : 1'b0);
    end
  end

  // Sends one word, lowest slice first, then lets go of the pins.
  task automatic send_word(input logic [31:0] w, input logic stb);
    for (int k = 0; k < 32 / WIDTH; k++) begin
      @(negedge clock_in);
      drv_en_q = 1'b1;
      drv_q = w[k*WIDTH +: WIDTH];
      strobe_level_out = stb;
    end
    @(negedge clock_in);
    drv_en_q = 1'b0;
    strobe_level_out = 1'b0;
  endtask

  // Board clock runs only on request and stands low otherwise.
  task automatic ext_clock(input int n);
    repeat (n) begin
      @(negedge clock_in);
      ext_clk_out = 1'b1;
      repeat (2) @(negedge clock_in);
      ext_clk_out = 1'b0;
      repeat (2) @(negedge clock_in);
    end
  endtask
endmodule

// ---- tb/timed_io_port_tb.sv ----
`timescale 1ns/1ns
module timed_io_port_tb;
  localparam int W = 8;
  localparam logic [31:0] WORD = 32'hddccbbaa;
  logic clock_in, rst_in, cmd_valid_in, cmd_ready_out, rsp_valid_out, event_out;
  logic strobe_in, strobe_out, ext_clk_pin_in, link_enable_in;
  timed_io_pkg::op_t cmd_op_in;
  logic [31:0] cmd_data_in, rsp_data_out, rsp;
  logic [7:0] cmd_arg_in;
  logic [W-1:0] pin_in, pin_out, pin_oe_out, link_pin_out_in, link_pin_oe_in;
  logic [W-1:0] narrow_claim_in, narrow_pin_out_in, narrow_pin_oe_in;
  logic [15:0] c0;
  int mismatches = 0;
  int checked = 0;
  int s;

  timed_io_port #(.WIDTH(W)) u_timed_io_port (
    .clock_in(clock_in), .rst_in(rst_in), .cmd_valid_in(cmd_valid_in), .cmd_op_in(cmd_op_in),
    .cmd_data_in(cmd_data_in), .cmd_arg_in(cmd_arg_in), .cmd_ready_out(cmd_ready_out),
    .rsp_valid_out(rsp_valid_out), .rsp_data_out(rsp_data_out), .event_out(event_out),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_out(pin_oe_out), .strobe_in(strobe_in),
    .strobe_out(strobe_out), .ext_clk_pin_in(ext_clk_pin_in), .link_enable_in(link_enable_in),
    .link_pin_out_in(link_pin_out_in), .link_pin_oe_in(link_pin_oe_in),
    .narrow_claim_in(narrow_claim_in), .narrow_pin_out_in(narrow_pin_out_in),
    .narrow_pin_oe_in(narrow_pin_oe_in));

  pin_partner #(.WIDTH(W)) u_pin_partner (
    .clock_in(clock_in), .pin_out_in(pin_out), .pin_oe_in(pin_oe_out), .level_out(pin_in),
    .strobe_level_out(strobe_in), .ext_clk_out(ext_clk_pin_in));

  // --------------------------------------------------------------------
  // Clock, tasks and watchdog
  // --------------------------------------------------------------------
  initial clock_in = 1'b0;
  always #5 clock_in = ~clock_in;

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Holds the command until it is taken; a missing answer reads as unknown.
  task automatic cmd(input timed_io_pkg::op_t op, input logic [31:0] d, input logic [7:0] a);
    int n;
    n = 0;
    @(negedge clock_in);
    cmd_valid_in = 1'b1;
    cmd_op_in = op;
    cmd_data_in = d;
    cmd_arg_in = a;
    #1;
    while (cmd_ready_out !== 1'b1 && n < 200) begin
      @(negedge clock_in);
      #1;
      n++;
    end
    check(32'(n < 200), 32'h1, "command never taken");
    @(negedge clock_in);
    cmd_valid_in = 1'b0;
    rsp = (rsp_valid_out === 1'b1) ? rsp_data_out : 32'hxxxxxxxx;
  endtask

  task automatic wait_event();
    int n;
    n = 0;
    while (event_out !== 1'b1 && n < 300) begin
      @(negedge clock_in);
      n++;
    end
    check(32'(n < 300), 32'h1, "no event");
  endtask

  task automatic print_verdict();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // A hang is cut well past the roughly 140 cycles the sequence needs.
  initial begin
    #100000;
    mismatches++;
    $display("[FAIL] %0t watchdog expired", $time);
    print_verdict();
  end

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    rst_in = 1'b1;
    cmd_valid_in = 1'b0;
    cmd_op_in = timed_io_pkg::OP_NOP;
    cmd_data_in = 32'h0;
    cmd_arg_in = 8'h00;
    link_enable_in = 1'b0;
    link_pin_out_in = 8'h00;
    link_pin_oe_in = 8'h00;
    narrow_claim_in = 8'h00;
    narrow_pin_out_in = 8'h00;
    narrow_pin_oe_in = 8'h00;
    repeat (6) @(negedge clock_in);
    rst_in = 1'b0;
    check(32'(pin_oe_out), 32'h0, "port off after reset");
    cmd(timed_io_pkg::OP_NOP, 32'h0, 8'h00);
    cmd(timed_io_pkg::OP_GET_COUNT, 32'h0, 8'h00);
    c0 = rsp[15:0];
    cmd(timed_io_pkg::OP_GET_COUNT, 32'h0, 8'h00);
    check(rsp, 32'(16'(c0 + 16'h0002)), "count on block 0");
    // Timed word with a narrow port holding the low nibble.
    narrow_claim_in = 8'h0f;
    narrow_pin_oe_in = 8'h0f;
    narrow_pin_out_in = 8'h09;
    cmd(timed_io_pkg::OP_CONFIG, 32'h11, 8'h00);
    cmd(timed_io_pkg::OP_GET_COUNT, 32'h0, 8'h00);
    c0 = rsp[15:0] + 16'h0028;
    cmd(timed_io_pkg::OP_SET_TIME, 32'(c0), 8'h00);
    cmd(timed_io_pkg::OP_OUT, WORD, 8'h00);
    wait_event();
    for (int k = 0; k < 4; k++) begin
      check(32'(pin_in), 32'({WORD[k*8+4 +: 4], 4'h9}), "slice");
      @(negedge clock_in);
    end
    cmd(timed_io_pkg::OP_GET_STAMP, 32'h0, 8'h00);
    check(rsp, 32'(c0), "timestamp");
    narrow_claim_in = 8'h00;
    // Open drain with outgoing strobe.
    cmd(timed_io_pkg::OP_CONFIG, 32'h1b, 8'h00);
    cmd(timed_io_pkg::OP_OUT, 32'h0000f00f, 8'h00);
    wait_event();
    s = 0;
    for (int k = 0; k < 8; k++) begin
      if (k < 2) begin
        check(32'(pin_oe_out), (k == 0) ? 32'hf0 : 32'h0f, "open drain");
      end
      s += int'(strobe_out === 1'b1);
      @(negedge clock_in);
    end
    check(32'(s), 32'h4, "strobe pulses");
    // Link takes every shared pin.
    link_enable_in = 1'b1;
    link_pin_out_in = 8'h5a;
    link_pin_oe_in = 8'hff;
    #1;
    check(32'(pin_in), 32'h5a, "link owns pins");
    @(negedge clock_in);
    link_enable_in = 1'b0;
    // Strobed input word, IN held off while the register is empty.
    cmd(timed_io_pkg::OP_CONFIG, 32'h14, 8'h00);
    fork
      cmd(timed_io_pkg::OP_IN, 32'h0, 8'h00);
      u_pin_partner.send_word(32'h44332211, 1'b1);
    join
    check(rsp, 32'h44332211, "input word");
    // Equal then unequal wait conditions.
    for (int k = 0; k < 2; k++) begin
      cmd(timed_io_pkg::OP_SET_COND, 32'h3c, 8'(k + 1));
      fork
        cmd(timed_io_pkg::OP_IN, 32'h0, 8'h00);
        u_pin_partner.send_word((k == 0) ? 32'h3c111111 : 32'h5a3c3c3c, 1'b1);
      join
      check(rsp, (k == 0) ? 32'h3c : 32'h5a, "condition sample");
    end
    // Block 1 from the board clock, divided by two.
    cmd(timed_io_pkg::OP_CLK_CONFIG, 32'h0101, 8'h01);
    cmd(timed_io_pkg::OP_CONFIG, 32'h111, 8'h00);
    cmd(timed_io_pkg::OP_GET_COUNT, 32'h0, 8'h00);
    c0 = rsp[15:0];
    cmd(timed_io_pkg::OP_GET_COUNT, 32'h0, 8'h00);
    check(rsp, 32'(c0), "count still without pin clock");
    u_pin_partner.ext_clock(6);
    cmd(timed_io_pkg::OP_GET_COUNT, 32'h0, 8'h00);
    check(rsp, 32'(16'(c0 + 16'h0003)), "divided pin clock");
    print_verdict();
  end
endmodule
